// ==== alarm_ctrl_pkg.sv ====
// Register map, field positions and reset values for the clock alarm block.
// Assumes page zero of the control port register space, 8-bit addresses and data.
package alarm_ctrl_pkg;

    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 8;

    // Register addresses
    localparam logic [7:0] ADDR_INPUT_ALARM_LIVE = 8'h0d;
    localparam logic [7:0] ADDR_LOCK_HOLDOVER_LIVE = 8'h0e;
    localparam logic [7:0] ADDR_CALIBRATION_LIVE = 8'h0f;
    localparam logic [7:0] ADDR_INTERNAL_FAULT_LATCHED = 8'h11;
    localparam logic [7:0] ADDR_INPUT_ALARM_LATCHED = 8'h12;
    localparam logic [7:0] ADDR_LOCK_HOLDOVER_LATCHED = 8'h13;
    localparam logic [7:0] ADDR_CALIBRATION_LATCHED = 8'h14;
    localparam logic [7:0] ADDR_INTERNAL_FAULT_MASK = 8'h17;
    localparam logic [7:0] ADDR_INPUT_ALARM_MASK = 8'h18;
    localparam logic [7:0] ADDR_LOCK_HOLDOVER_MASK = 8'h19;
    localparam logic [7:0] ADDR_CALIBRATION_MASK = 8'h1a;
    localparam logic [7:0] ADDR_SOFT_REINIT_CONTROL = 8'h1c;
    localparam logic [7:0] ADDR_FREQUENCY_STEP_CONTROL = 8'h1d;
    localparam logic [7:0] ADDR_POWER_RESET_ALIGN_CONTROL = 8'h1e;
    localparam logic [7:0] ADDR_SERIAL_WIRING_SELECT = 8'h2b;

    // Field positions
    localparam int unsigned SIGNAL_ABSENT_LSB = 0;
    localparam int unsigned FREQ_DEVIATION_LSB = 4;
    localparam int unsigned MAX_INPUTS = 4;
    localparam int unsigned BIT_DEVICE_CALIBRATING = 1 - 1;
    localparam int unsigned BIT_REFERENCE_ABSENT = 1;
    localparam int unsigned BIT_BUS_TIMEOUT = 5;
    localparam int unsigned BIT_PLL_UNLOCKED = 1;
    localparam int unsigned BIT_FREE_RUNNING = 5;
    localparam int unsigned BIT_CALIBRATION_BUSY = 5;
    localparam int unsigned BIT_SOFT_REINIT = 0;
    localparam int unsigned BIT_FREQ_STEP_UP = 0;
    localparam int unsigned BIT_FREQ_STEP_DOWN = 1;
    localparam int unsigned BIT_LOW_POWER = 0;
    localparam int unsigned BIT_HARD_RESET = 1;
    localparam int unsigned BIT_DIVIDER_ALIGN = 2;
    localparam int unsigned BIT_THREE_WIRE = 3;

    // Implemented bits per register
    localparam logic [7:0] VALID_INTERNAL_FAULT = 8'h23;
    localparam logic [7:0] VALID_INPUT_ALARM = 8'hff;
    localparam logic [7:0] VALID_LOCK_HOLDOVER = 8'h22;
    localparam logic [7:0] VALID_CALIBRATION = 8'h20;

    // Reset values
    localparam logic [7:0] MASK_RESET = 8'h00;
    localparam logic [7:0] FLAG_RESET = 8'h00;
    localparam logic [7:0] READ_ZERO = 8'h00;

endpackage : alarm_ctrl_pkg

// ==== sticky_flag_bank.sv ====
// Bank of sticky flags: set by a live condition, cleared per bit by a host write of zero.
// Assumes live conditions and clear strobes are synchronous to mclk_i.
module sticky_flag_bank #(
    parameter int unsigned WIDTH = 8
) (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic sys_rst_i,
    // Conditions and clears
    input wire logic [WIDTH-1:0] live_i,
    input wire logic [WIDTH-1:0] clear_i,
    // Flags
    output logic [WIDTH-1:0] flags_o
);

    initial begin
        if (WIDTH < 1 || WIDTH > 32) begin
            $error("sticky_flag_bank: WIDTH out of range");
        end
    end

    logic [WIDTH-1:0] flags_r;
    logic [WIDTH-1:0] flags_nxt;

    // A condition present in the clearing cycle keeps the flag set
    assign flags_nxt = (flags_r & ~clear_i) | live_i;

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            flags_r <= '0;
        end else begin
            flags_r <= flags_nxt;
        end
    end

    assign flags_o = flags_r;

    property p_set_by_live;
        @(posedge mclk_i) disable iff (sys_rst_i)
        (|live_i) |=> ((flags_r & $past(live_i)) == $past(live_i));
    endproperty
    a_set_by_live: assert property (p_set_by_live) else $error("live condition did not set flag");

    property p_hold_until_clear;
        @(posedge mclk_i) disable iff (sys_rst_i)
        (clear_i == '0) |=> ((flags_r & $past(flags_r)) == $past(flags_r));
    endproperty
    a_hold_until_clear: assert property (p_hold_until_clear) else $error("flag dropped without clear");

    property p_clear_drops;
        @(posedge mclk_i) disable iff (sys_rst_i)
        (|(clear_i & ~live_i)) |=> ((flags_r & $past(clear_i & ~live_i)) == '0);
    endproperty
    a_clear_drops: assert property (p_clear_drops) else $error("cleared flag stayed set");

endmodule : sticky_flag_bank

// ==== clock_alarm_status_and_control.sv ====
// Alarm status, sticky flags, interrupt masks and control bits of the clock device.
// Assumes the serial port engine presents decoded single-cycle register accesses.
// Functional notes
// - Live register bits 3:0 show signal loss.
// - Live register bits 7:4 show frequency deviation.
// - Live alarm bits follow condition, never latch.
// - Lock status bit 1 shows PLL unlocked.
// - Lock status bit 5 shows holdover/free run.
// - Calibration status bit 5 shows calibration busy.
// - Latched internal faults at bits 0,1,5.
// - Latched flag cleared only by writing zero.
// - Latched per-input loss and frequency flags.
// - Latched unlocked bit 1, holdover bit 5.
// - Latched calibration busy flag at bit 5.
// - Fault mask bits 0,1,5 block interrupt.
// - Per-input mask bits block interrupt.
// - Lock mask bits 1,5 block interrupt.
// - Calibration mask bit 5 blocks interrupt.
// - Soft reset bit 0 self-clearing reinit.
// - Step bit 0 rising raises frequency.
// - Step bit 1 rising lowers frequency.
// - Power bit 0 holds low power mode.
// - Hard reset bit 1 held until rewritten.
// - Power bit 2 pulses divider alignment.
// - Wiring bit 3 selects three-wire port.
// - Live internal status bits 0,1,5; they have no readable live register here, they only set the latched flags.
module clock_alarm_status_and_control #(
    parameter int unsigned NUM_INPUTS = 4
) (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic sys_rst_i,
    // Register access from the serial port engine
    input wire logic [alarm_ctrl_pkg::ADDR_W-1:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [alarm_ctrl_pkg::DATA_W-1:0] reg_wdata_i,
    output logic [alarm_ctrl_pkg::DATA_W-1:0] reg_rdata_o,
    output logic reg_rvalid_o,
    // Live conditions from the monitors
    input wire logic [NUM_INPUTS-1:0] signal_absent_live_i,
    input wire logic [NUM_INPUTS-1:0] freq_deviation_live_i,
    input wire logic pll_unlocked_live_i,
    input wire logic free_running_live_i,
    input wire logic calibration_busy_live_i,
    input wire logic device_calibrating_i,
    input wire logic reference_pins_signal_absent_i,
    input wire logic bus_timeout_i,
    // Interrupt
    output logic interrupt_output_pin_o,
    // Control outputs
    output logic soft_reinit_o,
    output logic freq_step_up_o,
    output logic freq_step_down_o,
    output logic low_power_request_o,
    output logic hard_reset_o,
    output logic divider_align_o,
    output logic serial_three_wire_select_o
);

    initial begin
        if (NUM_INPUTS < 1 || NUM_INPUTS > alarm_ctrl_pkg::MAX_INPUTS) begin
            $error("clock_alarm_status_and_control: NUM_INPUTS out of range");
        end
    end

    typedef logic [alarm_ctrl_pkg::DATA_W-1:0] byte_t;

    // Write strobe to a given register
    function automatic logic wr_hit(input logic [7:0] addr);
        wr_hit = reg_wr_i && (reg_addr_i == addr);
    endfunction : wr_hit

    // Bits that a write of zero clears in a latched register
    function automatic byte_t clear_vec(input logic [7:0] addr, input byte_t valid);
        clear_vec = wr_hit(addr) ? (~reg_wdata_i & valid) : alarm_ctrl_pkg::READ_ZERO;
    endfunction : clear_vec

    // Live views
    byte_t input_live;
    byte_t lock_live;
    byte_t cal_live;
    byte_t fault_live;

    always_comb begin
        input_live = alarm_ctrl_pkg::READ_ZERO;
        for (int n = 0; n < NUM_INPUTS; n++) begin
            input_live[alarm_ctrl_pkg::SIGNAL_ABSENT_LSB + n] = signal_absent_live_i[n];
            input_live[alarm_ctrl_pkg::FREQ_DEVIATION_LSB + n] = freq_deviation_live_i[n];
        end
    end

    always_comb begin
        lock_live = alarm_ctrl_pkg::READ_ZERO;
        lock_live[alarm_ctrl_pkg::BIT_PLL_UNLOCKED] = pll_unlocked_live_i;
        lock_live[alarm_ctrl_pkg::BIT_FREE_RUNNING] = free_running_live_i;
    end

    always_comb begin
        cal_live = alarm_ctrl_pkg::READ_ZERO;
        cal_live[alarm_ctrl_pkg::BIT_CALIBRATION_BUSY] = calibration_busy_live_i;
    end

    always_comb begin
        fault_live = alarm_ctrl_pkg::READ_ZERO;
        fault_live[alarm_ctrl_pkg::BIT_DEVICE_CALIBRATING] = device_calibrating_i;
        fault_live[alarm_ctrl_pkg::BIT_REFERENCE_ABSENT] = reference_pins_signal_absent_i;
        fault_live[alarm_ctrl_pkg::BIT_BUS_TIMEOUT] = bus_timeout_i;
    end

    // Sticky flags
    byte_t fault_flags;
    byte_t input_flags;
    byte_t lock_flags;
    byte_t cal_flags;

    sticky_flag_bank #(.WIDTH(alarm_ctrl_pkg::DATA_W)) u_fault_flags (
        .mclk_i(mclk_i),
        .sys_rst_i(sys_rst_i),
        .live_i(fault_live),
        .clear_i(clear_vec(alarm_ctrl_pkg::ADDR_INTERNAL_FAULT_LATCHED, alarm_ctrl_pkg::VALID_INTERNAL_FAULT)),
        .flags_o(fault_flags)
    );

    sticky_flag_bank #(.WIDTH(alarm_ctrl_pkg::DATA_W)) u_input_flags (
        .mclk_i(mclk_i),
        .sys_rst_i(sys_rst_i),
        .live_i(input_live),
        .clear_i(clear_vec(alarm_ctrl_pkg::ADDR_INPUT_ALARM_LATCHED, alarm_ctrl_pkg::VALID_INPUT_ALARM)),
        .flags_o(input_flags)
    );

    sticky_flag_bank #(.WIDTH(alarm_ctrl_pkg::DATA_W)) u_lock_flags (
        .mclk_i(mclk_i),
        .sys_rst_i(sys_rst_i),
        .live_i(lock_live),
        .clear_i(clear_vec(alarm_ctrl_pkg::ADDR_LOCK_HOLDOVER_LATCHED, alarm_ctrl_pkg::VALID_LOCK_HOLDOVER)),
        .flags_o(lock_flags)
    );

    sticky_flag_bank #(.WIDTH(alarm_ctrl_pkg::DATA_W)) u_cal_flags (
        .mclk_i(mclk_i),
        .sys_rst_i(sys_rst_i),
        .live_i(cal_live),
        .clear_i(clear_vec(alarm_ctrl_pkg::ADDR_CALIBRATION_LATCHED, alarm_ctrl_pkg::VALID_CALIBRATION)),
        .flags_o(cal_flags)
    );

    // Interrupt masks; unimplemented bits are not stored and read as zero
    byte_t fault_mask_r;
    byte_t input_mask_r;
    byte_t lock_mask_r;
    byte_t cal_mask_r;

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            fault_mask_r <= alarm_ctrl_pkg::MASK_RESET;
            input_mask_r <= alarm_ctrl_pkg::MASK_RESET;
            lock_mask_r <= alarm_ctrl_pkg::MASK_RESET;
            cal_mask_r <= alarm_ctrl_pkg::MASK_RESET;
        end else begin
            if (wr_hit(alarm_ctrl_pkg::ADDR_INTERNAL_FAULT_MASK)) begin
                fault_mask_r <= reg_wdata_i & alarm_ctrl_pkg::VALID_INTERNAL_FAULT;
            end
            if (wr_hit(alarm_ctrl_pkg::ADDR_INPUT_ALARM_MASK)) begin
                input_mask_r <= reg_wdata_i & alarm_ctrl_pkg::VALID_INPUT_ALARM;
            end
            if (wr_hit(alarm_ctrl_pkg::ADDR_LOCK_HOLDOVER_MASK)) begin
                lock_mask_r <= reg_wdata_i & alarm_ctrl_pkg::VALID_LOCK_HOLDOVER;
            end
            if (wr_hit(alarm_ctrl_pkg::ADDR_CALIBRATION_MASK)) begin
                cal_mask_r <= reg_wdata_i & alarm_ctrl_pkg::VALID_CALIBRATION;
            end
        end
    end

    // Interrupt is registered so the pin never glitches on a mask write
    logic irq_r;
    logic irq_nxt;

    always_comb begin
        irq_nxt = |(fault_flags & ~fault_mask_r & alarm_ctrl_pkg::VALID_INTERNAL_FAULT);
        irq_nxt = irq_nxt | (|(input_flags & ~input_mask_r));
        irq_nxt = irq_nxt | (|(lock_flags & ~lock_mask_r & alarm_ctrl_pkg::VALID_LOCK_HOLDOVER));
        irq_nxt = irq_nxt | (|(cal_flags & ~cal_mask_r & alarm_ctrl_pkg::VALID_CALIBRATION));
    end

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= irq_nxt;
        end
    end

    assign interrupt_output_pin_o = irq_r;

    // Self-clearing strobes: high for the one cycle after each accepted write of one
    logic soft_reinit_r;
    logic step_up_r;
    logic step_down_r;
    logic divider_align_r;

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            soft_reinit_r <= 1'b0;
            step_up_r <= 1'b0;
            step_down_r <= 1'b0;
            divider_align_r <= 1'b0;
        end else begin
            soft_reinit_r <= wr_hit(alarm_ctrl_pkg::ADDR_SOFT_REINIT_CONTROL)
                && reg_wdata_i[alarm_ctrl_pkg::BIT_SOFT_REINIT];
            step_up_r <= wr_hit(alarm_ctrl_pkg::ADDR_FREQUENCY_STEP_CONTROL)
                && reg_wdata_i[alarm_ctrl_pkg::BIT_FREQ_STEP_UP];
            step_down_r <= wr_hit(alarm_ctrl_pkg::ADDR_FREQUENCY_STEP_CONTROL)
                && reg_wdata_i[alarm_ctrl_pkg::BIT_FREQ_STEP_DOWN];
            divider_align_r <= wr_hit(alarm_ctrl_pkg::ADDR_POWER_RESET_ALIGN_CONTROL)
                && reg_wdata_i[alarm_ctrl_pkg::BIT_DIVIDER_ALIGN];
        end
    end

    // Level controls; hard reset spares this block so the host can clear it
    logic low_power_r;
    logic hard_reset_r;
    logic three_wire_r;

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            low_power_r <= 1'b0;
            hard_reset_r <= 1'b0;
        end else if (wr_hit(alarm_ctrl_pkg::ADDR_POWER_RESET_ALIGN_CONTROL)) begin
            low_power_r <= reg_wdata_i[alarm_ctrl_pkg::BIT_LOW_POWER];
            hard_reset_r <= reg_wdata_i[alarm_ctrl_pkg::BIT_HARD_RESET];
        end
    end

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            three_wire_r <= 1'b0;
        end else if (wr_hit(alarm_ctrl_pkg::ADDR_SERIAL_WIRING_SELECT)) begin
            three_wire_r <= reg_wdata_i[alarm_ctrl_pkg::BIT_THREE_WIRE];
        end
    end

    assign soft_reinit_o = soft_reinit_r;
    assign freq_step_up_o = step_up_r;
    assign freq_step_down_o = step_down_r;
    assign divider_align_o = divider_align_r;
    assign low_power_request_o = low_power_r;
    assign hard_reset_o = hard_reset_r;
    assign serial_three_wire_select_o = three_wire_r;

    // Read path; strobe bits always read back as zero
    byte_t rdata_nxt;
    byte_t rdata_r;
    logic rvalid_r;

    always_comb begin
        rdata_nxt = alarm_ctrl_pkg::READ_ZERO;
        unique case (reg_addr_i)
            alarm_ctrl_pkg::ADDR_INPUT_ALARM_LIVE: rdata_nxt = input_live;
            alarm_ctrl_pkg::ADDR_LOCK_HOLDOVER_LIVE: rdata_nxt = lock_live;
            alarm_ctrl_pkg::ADDR_CALIBRATION_LIVE: rdata_nxt = cal_live;
            alarm_ctrl_pkg::ADDR_INTERNAL_FAULT_LATCHED: rdata_nxt = fault_flags;
            alarm_ctrl_pkg::ADDR_INPUT_ALARM_LATCHED: rdata_nxt = input_flags;
            alarm_ctrl_pkg::ADDR_LOCK_HOLDOVER_LATCHED: rdata_nxt = lock_flags;
            alarm_ctrl_pkg::ADDR_CALIBRATION_LATCHED: rdata_nxt = cal_flags;
            alarm_ctrl_pkg::ADDR_INTERNAL_FAULT_MASK: rdata_nxt = fault_mask_r;
            alarm_ctrl_pkg::ADDR_INPUT_ALARM_MASK: rdata_nxt = input_mask_r;
            alarm_ctrl_pkg::ADDR_LOCK_HOLDOVER_MASK: rdata_nxt = lock_mask_r;
            alarm_ctrl_pkg::ADDR_CALIBRATION_MASK: rdata_nxt = cal_mask_r;
            alarm_ctrl_pkg::ADDR_POWER_RESET_ALIGN_CONTROL: begin
                rdata_nxt[alarm_ctrl_pkg::BIT_LOW_POWER] = low_power_r;
                rdata_nxt[alarm_ctrl_pkg::BIT_HARD_RESET] = hard_reset_r;
            end
            alarm_ctrl_pkg::ADDR_SERIAL_WIRING_SELECT: begin
                rdata_nxt[alarm_ctrl_pkg::BIT_THREE_WIRE] = three_wire_r;
            end
            default: rdata_nxt = alarm_ctrl_pkg::READ_ZERO;
        endcase
    end

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            rdata_r <= alarm_ctrl_pkg::READ_ZERO;
            rvalid_r <= 1'b0;
        end else begin
            rvalid_r <= reg_rd_i;
            if (reg_rd_i) begin
                rdata_r <= rdata_nxt;
            end
        end
    end

    assign reg_rdata_o = rdata_r;
    assign reg_rvalid_o = rvalid_r;

    // Checks
    logic rd_input_live;
    logic rd_lock_live;
    assign rd_input_live = reg_rd_i && (reg_addr_i == alarm_ctrl_pkg::ADDR_INPUT_ALARM_LIVE);
    assign rd_lock_live = reg_rd_i && (reg_addr_i == alarm_ctrl_pkg::ADDR_LOCK_HOLDOVER_LIVE);

    property p_los_live_read;
        @(posedge mclk_i) disable iff (sys_rst_i)
        rd_input_live |=> reg_rvalid_o && (reg_rdata_o[NUM_INPUTS-1:0] == $past(signal_absent_live_i));
    endproperty
    a_los_live_read: assert property (p_los_live_read) else $error("signal loss live bits wrong");

    property p_oof_live_read;
        @(posedge mclk_i) disable iff (sys_rst_i)
        rd_input_live |=> (reg_rdata_o[alarm_ctrl_pkg::FREQ_DEVIATION_LSB] == $past(freq_deviation_live_i[0]));
    endproperty
    a_oof_live_read: assert property (p_oof_live_read) else $error("frequency live bit wrong");

    property p_live_not_latched;
        @(posedge mclk_i) disable iff (sys_rst_i)
        (rd_input_live && signal_absent_live_i == '0 && freq_deviation_live_i == '0)
            |=> (reg_rdata_o == alarm_ctrl_pkg::READ_ZERO);
    endproperty
    a_live_not_latched: assert property (p_live_not_latched) else $error("live alarm read stale");

    property p_lock_live_read;
        @(posedge mclk_i) disable iff (sys_rst_i)
        rd_lock_live |=> (reg_rdata_o[alarm_ctrl_pkg::BIT_PLL_UNLOCKED] == $past(pll_unlocked_live_i))
            && (reg_rdata_o[alarm_ctrl_pkg::BIT_FREE_RUNNING] == $past(free_running_live_i));
    endproperty
    a_lock_live_read: assert property (p_lock_live_read) else $error("lock live bits wrong");

    property p_soft_reinit_pulse;
        @(posedge mclk_i) disable iff (sys_rst_i)
        (wr_hit(alarm_ctrl_pkg::ADDR_SOFT_REINIT_CONTROL) && reg_wdata_i[alarm_ctrl_pkg::BIT_SOFT_REINIT])
            |=> soft_reinit_o ##1 !soft_reinit_o || $past(reg_wr_i);
    endproperty
    a_soft_reinit_pulse: assert property (p_soft_reinit_pulse) else $error("reinit not a pulse");

    property p_step_exclusive_cause;
        @(posedge mclk_i) disable iff (sys_rst_i)
        (freq_step_up_o || freq_step_down_o)
            |-> $past(reg_wr_i) && ($past(reg_addr_i) == alarm_ctrl_pkg::ADDR_FREQUENCY_STEP_CONTROL);
    endproperty
    a_step_exclusive_cause: assert property (p_step_exclusive_cause) else $error("step without write");

    property p_step_down;
        @(posedge mclk_i) disable iff (sys_rst_i)
        (wr_hit(alarm_ctrl_pkg::ADDR_FREQUENCY_STEP_CONTROL) && !reg_wdata_i[alarm_ctrl_pkg::BIT_FREQ_STEP_DOWN])
            |=> !freq_step_down_o;
    endproperty
    a_step_down: assert property (p_step_down) else $error("step down on zero write");

    property p_hard_reset_holds;
        @(posedge mclk_i) disable iff (sys_rst_i)
        (hard_reset_o && !wr_hit(alarm_ctrl_pkg::ADDR_POWER_RESET_ALIGN_CONTROL)) |=> hard_reset_o;
    endproperty
    a_hard_reset_holds: assert property (p_hard_reset_holds) else $error("hard reset cleared itself");

    property p_low_power;
        @(posedge mclk_i) disable iff (sys_rst_i)
        wr_hit(alarm_ctrl_pkg::ADDR_POWER_RESET_ALIGN_CONTROL)
            |=> (low_power_request_o == $past(reg_wdata_i[alarm_ctrl_pkg::BIT_LOW_POWER]));
    endproperty
    a_low_power: assert property (p_low_power) else $error("low power bit not taken");

    property p_irq_follows;
        @(posedge mclk_i) disable iff (sys_rst_i)
        (|(input_flags & ~input_mask_r)) |=> interrupt_output_pin_o;
    endproperty
    a_irq_follows: assert property (p_irq_follows) else $error("unmasked flag gave no interrupt");

    c_irq_raised: cover property (@(posedge mclk_i) disable iff (sys_rst_i) $rose(interrupt_output_pin_o));
    c_irq_cleared: cover property (@(posedge mclk_i) disable iff (sys_rst_i) $fell(interrupt_output_pin_o));
    c_step_up: cover property (@(posedge mclk_i) disable iff (sys_rst_i) freq_step_up_o);
    c_hard_reset: cover property (@(posedge mclk_i) disable iff (sys_rst_i) $fell(hard_reset_o));

endmodule : clock_alarm_status_and_control

// ==== host_port_model.sv ====
// Host side of the register port: one single-cycle write or read strobe per call.
// Assumes the bench calls acc; requests change at the falling edge only.
module host_port_model (
    // Clock
    input wire logic mclk_i,
    // Register strobes
    output logic [7:0] reg_addr_o,
    output logic reg_wr_o,
    output logic reg_rd_o,
    output logic [7:0] reg_wdata_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        reg_addr_o = 8'h00;
        reg_wr_o = 1'b0;
        reg_rd_o = 1'b0;
        reg_wdata_o = 8'h00;
    end
    // Released address and data show the inverse so no stale value can pass for a live one
    task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(negedge mclk_i);
        reg_wr_o = w;
        reg_rd_o = !w;
        reg_addr_o = a;
        reg_wdata_o = d;
        @(negedge mclk_i);
        reg_wr_o = 1'b0;
        reg_rd_o = 1'b0;
        reg_addr_o = ~a;
        reg_wdata_o = ~d;
    endtask : acc
endmodule : host_port_model

// ==== clock_alarm_status_and_control_tb.sv ====
// Self-checking bench for the alarm status and control block.
// Assumes the host model drives the register port; monitor inputs are driven here.
module clock_alarm_status_and_control_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic [7:0] addr, wdata, rdata, v;
    logic wr_s, rd_s, rvalid, irq;
    logic [3:0] sig = 4'h0;
    logic [3:0] frq = 4'h0;
    logic [5:0] one = 6'h00;
    logic [6:0] ctl;
    logic [7:0] exp_q[$];
    int n_mismatch = 0;
    int compares = 0;
    localparam logic [7:0] LIVE[4] = '{8'h0d, 8'h0e, 8'h0f, 8'h00};
    localparam logic [7:0] LAT[4] = '{8'h12, 8'h13, 8'h14, 8'h11};
    localparam logic [7:0] MSK[4] = '{8'h18, 8'h19, 8'h1a, 8'h17};
    localparam logic [7:0] VAL[4] = '{8'hff, 8'h22, 8'h20, 8'h23};
    initial begin
        forever #5 mclk_i = ~mclk_i;
    end
    host_port_model i_host_port_model (.mclk_i(mclk_i), .reg_addr_o(addr), .reg_wr_o(wr_s), .reg_rd_o(rd_s),
        .reg_wdata_o(wdata));
    clock_alarm_status_and_control i_clock_alarm_status_and_control (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i),
        .reg_addr_i(addr), .reg_wr_i(wr_s), .reg_rd_i(rd_s), .reg_wdata_i(wdata), .reg_rdata_o(rdata),
        .reg_rvalid_o(rvalid), .signal_absent_live_i(sig), .freq_deviation_live_i(frq),
        .pll_unlocked_live_i(one[5]), .free_running_live_i(one[4]), .calibration_busy_live_i(one[3]),
        .device_calibrating_i(one[2]), .reference_pins_signal_absent_i(one[1]), .bus_timeout_i(one[0]),
        .interrupt_output_pin_o(irq), .soft_reinit_o(ctl[6]), .freq_step_up_o(ctl[5]),
        .freq_step_down_o(ctl[4]), .divider_align_o(ctl[3]), .low_power_request_o(ctl[2]),
        .hard_reset_o(ctl[1]), .serial_three_wire_select_o(ctl[0]));
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: got %h want %h", $time, seen, exp);
        end
    endtask : check
    task automatic results;
        if (n_mismatch == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : results
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        i_host_port_model.acc(1'b0, a, 8'h00);
    endtask : rd
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        i_host_port_model.acc(1'b1, a, d);
    endtask : wr
    // Maps a register-shaped value onto the monitor inputs of one alarm group
    task automatic drive(input int g, input logic [7:0] x);
        @(negedge mclk_i);
        case (g)
            0: {frq, sig} = x;
            1: {one[5], one[4]} = {x[1], x[5]};
            2: one[3] = x[5];
            default: {one[2], one[1], one[0]} = {x[0], x[1], x[5]};
        endcase
    endtask : drive
    // Flag then interrupt register: two edges, one spare
    task automatic irq_is(input logic e);
        repeat (3) @(negedge mclk_i);
        check({7'h00, irq}, {7'h00, e});
    endtask : irq_is
    always @(negedge mclk_i) begin
        if (rvalid === 1'b1) begin
            check(rdata, exp_q.pop_front());
        end
    end
    initial begin
        #100us;
        n_mismatch++;
        results();
    end
    initial begin
        void'($urandom(32'hfc82));
        repeat (20) @(negedge mclk_i);
        sys_rst_i = 1'b0;
        @(negedge mclk_i);
        check({1'b0, ctl}, 8'h00);
        for (int g = 0; g < 4; g++) begin
            v = 8'($urandom) & VAL[g];
            if (v == 8'h00) v = VAL[g];
            rd(MSK[g], 8'h00);
            drive(g, v);
            if (g < 3) rd(LIVE[g], v);
            drive(g, 8'h00);
            if (g < 3) rd(LIVE[g], 8'h00);
            rd(LAT[g], v);
            irq_is(1'b1);
            wr(MSK[g], v);
            rd(MSK[g], v);
            irq_is(1'b0);
            wr(MSK[g], 8'h00);
            irq_is(1'b1);
            wr(LAT[g], v);
            rd(LAT[g], v);
            wr(LAT[g], 8'h00);
            rd(LAT[g], 8'h00);
            irq_is(1'b0);
        end
        wr(8'h1c, 8'h00);
        check({1'b0, ctl}, 8'h00);
        wr(8'h1c, 8'h01);
        check({1'b0, ctl}, 8'h40);
        wr(8'h1d, 8'h03);
        check({1'b0, ctl}, 8'h30);
        wr(8'h1e, 8'h07);
        check({1'b0, ctl}, 8'h0e);
        @(negedge mclk_i);
        check({1'b0, ctl}, 8'h06);
        rd(8'h1e, 8'h03);
        wr(8'h1e, 8'h00);
        check({1'b0, ctl}, 8'h00);
        wr(8'h2b, 8'h08);
        check({1'b0, ctl}, 8'h01);
        rd(8'h2b, 8'h08);
        rd(8'h20, 8'h00);
        rd(8'h1c, 8'h00);
        repeat (4) @(negedge mclk_i);
        results();
    end
endmodule : clock_alarm_status_and_control_tb
